// ==== ecu_core.sv ====
// Purpose: Exception and interrupt acceptance, entry save and return
// Assumes: All inputs synchronous to i_clk_sys; pipeline stalls on o_busy
// Notes: Hardware updates win over a same-cycle software register write
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module ecu_core
  import ecu_pkg::*;
#(
  parameter logic [31:0] P_EXC_VECTOR = 32'h0000_0100,
  parameter logic [31:0] P_INT_VECTOR = 32'h0000_0600,
  parameter logic [31:0] P_RST_VECTOR = 32'h0000_0000,
  parameter logic [31:0] P_IRQ_CODE = 32'h0000_0200,
  parameter logic [31:0] P_NMI_CODE = 32'h0000_01C0,
  parameter logic [31:0] P_CHK_CODE = 32'h0000_00E0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Pipeline events
  input wire ecu_exc_s i_exc,
  input wire logic i_chk_valid,
  input wire logic i_chk_second_xfer,
  input wire logic i_chk_fault_a,
  input wire logic i_chk_fault_b,
  input wire logic [31:0] i_chk_pc,
  input wire ecu_call_s i_call,
  input wire logic i_rte,
  input wire logic [31:0] i_int_next_pc,
  input wire logic i_sleep,
  // Interrupt sources, one-cycle request pulses
  input wire logic i_irq,
  input wire logic i_nmi,
  // Register port
  input wire logic [ECU_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [31:0] o_rdata,
  // Results toward the pipeline
  output ecu_redir_s o_redir,
  output logic o_manual_reset,
  output logic o_int_ack,
  output logic o_busy,
  output logic [31:0] o_status,
  output logic [31:0] o_proc_ret
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ecu_state_e state_q;
  ecu_state_e state_d;
  logic [31:0] status_q;
  logic [31:0] saved_pc_q;
  logic [31:0] saved_st_q;
  logic [31:0] exc_code_q;
  logic [31:0] int_code_q;
  logic [31:0] proc_ret_q;
  logic [31:0] redir_pc_q;
  logic [31:0] rdata_q;
  logic nmi_accept_q;
  logic irq_pend_q;
  logic nmi_pend_q;
  logic int_ack_q;
  logic chk_fault;
  logic block_bit;
  logic running;
  logic exc_any;
  logic take_mrst;
  logic take_exc;
  logic take_nmi;
  logic take_irq;
  logic take_int;
  logic take_rte;
  logic [31:0] spc_sel;
  ecu_exc_s exc_eff;

  // Write strobe decode shared by several registers
  function automatic logic wr_hit(input logic we,
                                  input logic [ECU_ADDR_W-1:0] addr,
                                  input logic [3:0] off);
    wr_hit = we & (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Second-step access check
  ecu_access_chk u_chk (
    .i_chk_valid(i_chk_valid),
    .i_second_xfer(i_chk_second_xfer),
    .i_fault_a(i_chk_fault_a),
    .i_fault_b(i_chk_fault_b),
    .o_fault(chk_fault),
    .o_fault_second()
  );

  // A failed access check becomes a re-execution exception at i_chk_pc;
  // pipeline exceptions take precedence since they are older
  always_comb begin
    exc_eff = i_exc;
    if (!i_exc.valid && chk_fault) begin
      exc_eff.valid = 1'b1;
      exc_eff.reexec = 1'b1;
      exc_eff.user_break = 1'b0;
      exc_eff.branch_ds = 1'b0;
      exc_eff.pc = i_chk_pc;
      exc_eff.code = P_CHK_CODE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance decisions
  assign block_bit = status_q[ECU_BL_POS];
  assign running = (state_q == ECU_ST_RUN);
  assign exc_any = running & exc_eff.valid;
  // User break is the only exception allowed through while blocked
  assign take_mrst = exc_any & block_bit & ~exc_eff.user_break;
  assign take_exc = exc_any & ~take_mrst;
  // Return only when no exception competes in the same cycle
  assign take_rte = running & i_rte & ~exc_any;
  // NMI beats ordinary requests; both wait behind exceptions and return
  assign take_nmi = running & ~exc_any & ~i_rte & nmi_pend_q
                    & (~block_bit | nmi_accept_q | i_sleep);
  assign take_irq = running & ~exc_any & ~i_rte & irq_pend_q & ~take_nmi
                    & (~block_bit | i_sleep);
  assign take_int = take_nmi | take_irq;

  ecu_spc_sel u_spc (
    .i_exc(exc_eff),
    .i_is_int(take_int),
    .i_int_next_pc(i_int_next_pc),
    .o_spc(spc_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control state: one cycle of redirect after each accepted event
  always_comb begin
    state_d = state_q;
    case (state_q)
      ECU_ST_RUN: begin
        if (take_mrst) begin
          state_d = ECU_ST_MRST;
        end else if (take_exc || take_int || take_rte) begin
          state_d = ECU_ST_JUMP;
        end
      end
      ECU_ST_JUMP: state_d = ECU_ST_RUN;
      ECU_ST_MRST: state_d = ECU_ST_RUN;
      default: state_d = ECU_ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_q <= ECU_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Redirect target chosen in the accept cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      redir_pc_q <= ECU_ZERO_RST;
    end else if (take_mrst) begin
      redir_pc_q <= P_RST_VECTOR;
    end else if (take_exc) begin
      redir_pc_q <= P_EXC_VECTOR;
    end else if (take_int) begin
      redir_pc_q <= P_INT_VECTOR;
    end else if (take_rte) begin
      redir_pc_q <= saved_pc_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word: entry blocks, return restores, manual reset reinitialises
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      status_q <= ECU_STATUS_RST;
    end else if (take_mrst) begin
      status_q <= ECU_STATUS_RST;
    end else if (take_exc || take_int) begin
      status_q[ECU_BL_POS] <= 1'b1;
    end else if (take_rte) begin
      status_q <= saved_st_q;
    end else if (wr_hit(i_we, i_addr, ECU_OFF_STATUS)) begin
      status_q <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Saved PC and saved status; left as they were on a manual reset
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      saved_pc_q <= ECU_ZERO_RST;
    end else if (take_exc || take_int) begin
      saved_pc_q <= spc_sel;
    end else if (wr_hit(i_we, i_addr, ECU_OFF_SAVED_PC)) begin
      saved_pc_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      saved_st_q <= ECU_ZERO_RST;
    end else if (take_exc || take_int) begin
      saved_st_q <= status_q;
    end else if (wr_hit(i_we, i_addr, ECU_OFF_SAVED_ST)) begin
      saved_st_q <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event codes
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      exc_code_q <= ECU_ZERO_RST;
    end else if (take_mrst) begin
      exc_code_q <= ECU_MRESET_CODE;
    end else if (take_exc) begin
      exc_code_q <= exc_eff.code;
    end else if (wr_hit(i_we, i_addr, ECU_OFF_EXC_CODE)) begin
      exc_code_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      int_code_q <= ECU_ZERO_RST;
    end else if (take_nmi) begin
      int_code_q <= P_NMI_CODE;
    end else if (take_irq) begin
      int_code_q <= P_IRQ_CODE;
    end else if (wr_hit(i_we, i_addr, ECU_OFF_INT_CODE)) begin
      int_code_q <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return-address register: only a re-execution fault on the call itself cancels it,
  // a re-execution fault in its delay slot does not
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      proc_ret_q <= ECU_ZERO_RST;
    end else if (i_call.we && !(take_exc && exc_eff.reexec
                                && !exc_eff.in_ds)) begin
      proc_ret_q <= i_call.ret_addr;
    end else if (wr_hit(i_we, i_addr, ECU_OFF_PROC_RET)) begin
      proc_ret_q <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // NMI policy bit, set by software
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      nmi_accept_q <= 1'b0;
    end else if (wr_hit(i_we, i_addr, ECU_OFF_CTRL)) begin
      nmi_accept_q <= i_wdata[ECU_CTRL_NMI_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending interrupts; a new request in the accept cycle survives
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      irq_pend_q <= 1'b0;
    end else if (i_irq) begin
      irq_pend_q <= 1'b1;
    end else if (take_irq) begin
      irq_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      nmi_pend_q <= 1'b0;
    end else if (i_nmi) begin
      nmi_pend_q <= 1'b1;
    end else if (take_nmi) begin
      nmi_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      int_ack_q <= 1'b0;
    end else begin
      int_ack_q <= take_int;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rdata_q <= ECU_ZERO_RST;
    end else if (i_re) begin
      case (i_addr)
        ECU_OFF_STATUS: rdata_q <= status_q;
        ECU_OFF_SAVED_PC: rdata_q <= saved_pc_q;
        ECU_OFF_SAVED_ST: rdata_q <= saved_st_q;
        ECU_OFF_EXC_CODE: rdata_q <= exc_code_q;
        ECU_OFF_INT_CODE: rdata_q <= int_code_q;
        ECU_OFF_PROC_RET: rdata_q <= proc_ret_q;
        ECU_OFF_CTRL: rdata_q <= {31'h0000_0000, nmi_accept_q};
        ECU_OFF_PEND: rdata_q <= {30'h0000_0000, nmi_pend_q, irq_pend_q};
        default: rdata_q <= ECU_ZERO_RST;
      endcase
    end else begin
      rdata_q <= ECU_ZERO_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; which access failed is not reported, only that one did
  assign o_rdata = rdata_q;
  assign o_redir.valid = (state_q == ECU_ST_JUMP)
                         | (state_q == ECU_ST_MRST);
  assign o_redir.pc = redir_pc_q;
  assign o_manual_reset = (state_q == ECU_ST_MRST);
  assign o_int_ack = int_ack_q;
  // Busy only while redirecting, so the pipeline holds one cycle
  assign o_busy = ~running;
  assign o_status = status_q;
  assign o_proc_ret = proc_ret_q;

endmodule // ecu_core

// ==== ecu_pkg.sv ====
// Purpose: Shared constants and carriers for the exception entry/return unit
// Assumes: 32-bit addresses and a 32-bit status word
// Notes: Register offsets index 32-bit words on the plain register port
package ecu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry and offsets
  localparam int ECU_ADDR_W = 4;
  localparam logic [3:0] ECU_OFF_STATUS = 4'h0;
  localparam logic [3:0] ECU_OFF_SAVED_PC = 4'h1;
  localparam logic [3:0] ECU_OFF_SAVED_ST = 4'h2;
  localparam logic [3:0] ECU_OFF_EXC_CODE = 4'h3;
  localparam logic [3:0] ECU_OFF_INT_CODE = 4'h4;
  localparam logic [3:0] ECU_OFF_PROC_RET = 4'h5;
  localparam logic [3:0] ECU_OFF_CTRL = 4'h6;
  localparam logic [3:0] ECU_OFF_PEND = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int ECU_BL_POS = 28;
  localparam int ECU_CTRL_NMI_POS = 0;
  localparam int ECU_PEND_IRQ_POS = 0;
  localparam int ECU_PEND_NMI_POS = 1;
  localparam logic [31:0] ECU_STATUS_RST = 32'h1000_0000;
  localparam logic [31:0] ECU_ZERO_RST = 32'h0000_0000;
  localparam logic [31:0] ECU_MRESET_CODE = 32'h0000_0020;

  ////////////////////////////////////////////////////////////////////////////
  // Control states, Gray coded along run -> jump and run -> manual reset
  typedef enum logic [1:0] {
    ECU_ST_RUN  = 2'b00,
    ECU_ST_JUMP = 2'b01,
    ECU_ST_MRST = 2'b10
  } ecu_state_e;

  // Exception report from the pipeline
  typedef struct packed {
    logic valid;        // Exception raised this cycle
    logic reexec;       // 1 re-execution type, 0 completion type
    logic user_break;   // Exception is a user break
    logic in_ds;        // Faulting instruction sits in a delay slot
    logic branch_ds;    // Faulting instruction is a delayed branch
    logic [31:0] code;  // Event code of this exception
    logic [31:0] pc;    // Address of the faulting instruction
    logic [31:0] next_pc; // Address of the following instruction
    logic [31:0] target;  // Branch destination when branch_ds
  } ecu_exc_s;

  // Subroutine call return-address write
  typedef struct packed {
    logic we;
    logic [31:0] ret_addr;
  } ecu_call_s;

  // Redirect to the fetch stage
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
  } ecu_redir_s;

endpackage : ecu_pkg

// ==== ecu_spc_sel.sv ====
// Purpose: Pick the address to keep in saved_pc for an accepted event
// Assumes: Pipeline supplies all candidate addresses in the event cycle
// Notes: Purely combinational
`timescale 1ns/1ps
module ecu_spc_sel
  import ecu_pkg::*;
(
  input wire ecu_exc_s i_exc,
  input wire logic i_is_int,
  input wire logic [31:0] i_int_next_pc,
  output logic [31:0] o_spc
);

  // Re-execution resumes at the fault, completion at the successor
  always_comb begin
    if (i_is_int) begin
      o_spc = i_int_next_pc;
    end else if (i_exc.reexec) begin
      // Delay-slot address kept whatever the branch condition was
      o_spc = i_exc.pc;
    end else if (i_exc.branch_ds) begin
      o_spc = i_exc.target;
    end else begin
      o_spc = i_exc.next_pc;
    end
  end

endmodule // ecu_spc_sel

// ==== ecu_access_chk.sv ====
// Purpose: Second-step exception check over one or two memory accesses
// Assumes: Fault flags for each access arrive in the check cycle
// Notes: Second access checked only when a second transfer exists
`timescale 1ns/1ps
module ecu_access_chk (
  input wire logic i_chk_valid,
  input wire logic i_second_xfer,
  input wire logic i_fault_a,
  input wire logic i_fault_b,
  output logic o_fault,
  output logic o_fault_second
);

  // Two checks when the slot instruction makes two transfers
  always_comb begin
    o_fault = i_chk_valid & (i_fault_a | (i_second_xfer & i_fault_b));
    // First access has priority in reporting
    o_fault_second = i_chk_valid & ~i_fault_a & i_second_xfer
                     & i_fault_b;
  end

endmodule // ecu_access_chk

// ==== ecu_pipe_model.sv ====
// Purpose: Fetch-side stand-in that supplies the next-instruction address
// Assumes: Fetch advances two bytes a cycle unless the core stalls it
// Notes: A redirect reloads the fetch address in the cycle it appears
`timescale 1ns/1ps
module ecu_pipe_model
  import ecu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire ecu_redir_s i_redir,
  input wire logic i_busy,
  output logic [31:0] o_next_pc
);
  logic [31:0] pc_q;
  // Fetch follows redirects and stalls while the core is busy
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pc_q <= 32'h0000_0000;
    end else if (i_redir.valid) begin
      pc_q <= i_redir.pc;
    end else if (!i_busy) begin
      pc_q <= pc_q + 32'h0000_0002;
    end
  end
  // Changes every cycle, so a stale save address shows up at once
  assign o_next_pc = pc_q + 32'h0000_0002;
endmodule // ecu_pipe_model

// ==== ecu_core_sva.sv ====
// Purpose: Port-level checks of exception entry, manual reset and interrupts
// Assumes: Single clock domain, synchronous active-high reset
// Notes: Saved registers are not ports, so saves are checked by the bench
`timescale 1ns/1ps
module ecu_chk
  import ecu_pkg::*;
#(
  parameter logic [31:0] P_EXC_VECTOR = 32'h0000_0100,
  parameter logic [31:0] P_INT_VECTOR = 32'h0000_0600,
  parameter logic [31:0] P_RST_VECTOR = 32'h0000_0000
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire ecu_exc_s i_exc,
  input wire logic i_chk_valid,
  input wire logic i_chk_second_xfer,
  input wire logic i_chk_fault_b,
  input wire ecu_call_s i_call,
  input wire logic i_rte,
  input wire logic i_sleep,
  input wire logic i_irq,
  input wire logic i_re,
  input wire logic [31:0] o_rdata,
  input wire ecu_redir_s o_redir,
  input wire logic o_manual_reset,
  input wire logic o_int_ack,
  input wire logic o_busy,
  input wire logic [31:0] o_status,
  input wire logic [31:0] o_proc_ret
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Redirect and entry behaviour
  a_redir_one_pulse: assert property (o_redir.valid |=> !o_redir.valid)
    else $error("redirect held longer than one cycle");
  a_mreset_target: assert property (o_manual_reset |-> o_redir.valid &&
    o_redir.pc == P_RST_VECTOR && o_status == ECU_STATUS_RST)
    else $error("manual reset without reset redirect");
  a_blocked_exc_reset: assert property (i_exc.valid && !i_exc.user_break &&
    o_status[ECU_BL_POS] && !o_busy |=> o_manual_reset)
    else $error("blocked exception did not reset");
  a_exc_entry: assert property (i_exc.valid && !o_busy &&
    !o_status[ECU_BL_POS] |=> o_redir.valid && !o_manual_reset &&
    o_redir.pc == P_EXC_VECTOR && o_status[ECU_BL_POS])
    else $error("exception entry wrong");
  a_call_kept: assert property (i_call.we && i_exc.valid && i_exc.reexec &&
    i_exc.in_ds && !o_busy && !o_status[ECU_BL_POS]
    |=> o_proc_ret == $past(i_call.ret_addr))
    else $error("slot fault dropped return address");
  a_second_check: assert property (i_chk_valid && i_chk_second_xfer &&
    i_chk_fault_b && !i_exc.valid && !o_busy && !o_status[ECU_BL_POS]
    |=> o_redir.valid && o_redir.pc == P_EXC_VECTOR)
    else $error("second access fault missed");
  a_int_entry: assert property (o_int_ack |-> o_redir.valid &&
    o_redir.pc == P_INT_VECTOR && o_status[ECU_BL_POS])
    else $error("interrupt entry wrong");
  a_sleep_accept: assert property ((i_irq && i_sleep && !o_busy) ##1
    (i_sleep && !o_busy && !i_exc.valid && !i_rte && !i_chk_valid)
    |=> o_int_ack)
    else $error("interrupt not taken in sleep");
  a_rdata_quiet: assert property (!$past(i_re) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  // Main scenarios reached
  c_mreset: cover property (o_manual_reset);
  c_sleep_ack: cover property (o_int_ack && i_sleep);
  c_exc: cover property (o_redir.valid && o_redir.pc == P_EXC_VECTOR);
endmodule // ecu_chk
bind ecu_core ecu_chk #(.P_EXC_VECTOR(P_EXC_VECTOR),
  .P_INT_VECTOR(P_INT_VECTOR), .P_RST_VECTOR(P_RST_VECTOR)) ecu_chk_i (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_exc(i_exc),
  .i_chk_valid(i_chk_valid), .i_chk_second_xfer(i_chk_second_xfer),
  .i_chk_fault_b(i_chk_fault_b), .i_call(i_call), .i_rte(i_rte),
  .i_sleep(i_sleep), .i_irq(i_irq), .i_re(i_re), .o_rdata(o_rdata),
  .o_redir(o_redir), .o_manual_reset(o_manual_reset),
  .o_int_ack(o_int_ack), .o_busy(o_busy), .o_status(o_status),
  .o_proc_ret(o_proc_ret));

// ==== tb.sv ====
// Purpose: Self-checking bench for exception entry, return and interrupts
// Assumes: Register port reads answer one cycle after the strobe
// Notes: Addresses and codes are random from a fixed seed
`timescale 1ns/1ps
module tb;
  import ecu_pkg::*;
  localparam logic [31:0] EXC_V = 32'h0000_0100;
  localparam logic [31:0] INT_V = 32'h0000_0600;
  localparam logic [31:0] RST_V = 32'h0000_0000;
  localparam logic [31:0] CHK_C = 32'h0000_00E0;
  logic i_clk_sys = 0, i_rst = 1, return_from_exception = 0, sleep = 0, irq = 0, nmi = 0;
  logic cv = 0, sxf = 0, fltb = 0, we = 0, re = 0, o_manual_reset, o_int_ack;
  logic o_busy, flta = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, chk_pc = 32'h0, o_rdata, o_status, o_proc_ret;
  logic [31:0] next_pc, np_prev, spc_exp, pr, st_exp;
  ecu_exc_s exc = '0, e;
  ecu_call_s call = '0, c;
  ecu_redir_s o_redir;
  int seed = 6632, err_count = 0, total_checks = 0, cyc = 0;
  ecu_core #(.P_EXC_VECTOR(EXC_V), .P_INT_VECTOR(INT_V), .P_RST_VECTOR(RST_V),
    .P_CHK_CODE(CHK_C)) ecu_core_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_exc(exc), .i_chk_valid(cv), .i_chk_second_xfer(sxf),
    .i_chk_fault_a(flta), .i_chk_fault_b(fltb), .i_chk_pc(chk_pc),
    .i_call(call), .i_rte(return_from_exception), .i_int_next_pc(next_pc), .i_sleep(sleep),
    .i_irq(irq), .i_nmi(nmi), .i_addr(addr), .i_wdata(wdata), .i_we(we),
    .i_re(re), .o_rdata(o_rdata), .o_redir(o_redir),
    .o_manual_reset(o_manual_reset), .o_int_ack(o_int_ack), .o_busy(o_busy),
    .o_status(o_status), .o_proc_ret(o_proc_ret));
  ecu_pipe_model ecu_pipe_model_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_redir(o_redir), .i_busy(o_busy), .o_next_pc(next_pc));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, plus the address the core sampled at the last edge
  initial begin
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) np_prev <= next_pc;
  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Register port: strobe one cycle, read data in the following cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk_sys);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    @(posedge i_clk_sys);
    re <= 1'b1;
    addr <= a;
    @(posedge i_clk_sys);
    re <= 1'b0;
    #1 chk(o_rdata, x);
  endtask
  // One pipeline event held for one cycle, redirect checked after it
  task automatic fire(input ecu_exc_s ev, input logic r, input ecu_call_s cl,
    input logic sx, input logic fb, input logic v, input logic [31:0] p);
    @(posedge i_clk_sys);
    exc <= ev;
    return_from_exception <= r;
    call <= cl;
    cv <= sx | fb;
    sxf <= sx;
    fltb <= fb;
    chk_pc <= ev.pc;
    @(posedge i_clk_sys);
    exc <= '0;
    return_from_exception <= 1'b0;
    call <= '0;
    cv <= 1'b0;
    sxf <= 1'b0;
    fltb <= 1'b0;
    #1 chk(o_redir.valid, v);
    chk(o_busy, v);
    if (v) chk(o_redir.pc, p);
  endtask
  // Optionally pulse a request; watch from the first edge, since a request
  // already pending is taken as soon as the block bit lets it through
  task automatic irq_go(input logic n, input logic p, input logic x);
    logic seen;
    seen = 1'b0;
    for (int k = 0; k < 7; k++) begin
      @(posedge i_clk_sys);
      irq <= p & (k == 0) & ~n;
      nmi <= p & (k == 0) & n;
      #1;
      if (o_int_ack === 1'b1 && !seen) begin
        seen = 1'b1;
        spc_exp = np_prev;
      end
    end
    chk(seen, x);
  endtask
  function automatic logic [31:0] exp_spc(input ecu_exc_s ev);
    if (ev.reexec) return ev.pc;
    return ev.branch_ds ? ev.target : ev.next_pc;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pr = 32'h0;
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(ECU_OFF_STATUS, ECU_STATUS_RST);
    rd(4'h8, 32'h0);
    // All four save kinds, each with a return-address write beside it
    for (int n = 0; n < 8; n++) begin
      wr(ECU_OFF_STATUS, 32'h0);
      e = '0;
      e.valid = 1'b1;
      e.reexec = n[0];
      e.in_ds = n[1] & n[0];
      e.branch_ds = n[1] & ~n[0];
      e.code = $random(seed);
      e.pc = $random(seed);
      e.next_pc = $random(seed);
      e.target = $random(seed);
      c.we = 1'b1;
      c.ret_addr = $random(seed);
      if (!(e.reexec && !e.in_ds)) pr = c.ret_addr;
      fire(e, 1'b0, c, 1'b0, 1'b0, 1'b1, EXC_V);
      chk(o_proc_ret, pr);
      rd(ECU_OFF_SAVED_PC, exp_spc(e));
      rd(ECU_OFF_EXC_CODE, e.code);
      rd(ECU_OFF_SAVED_ST, 32'h0);
    end
    // Return restores both saved values; block bit stays set after it
    c = '0;
    spc_exp = $random(seed);
    st_exp = $random(seed) | 32'h1000_0000;
    wr(ECU_OFF_SAVED_PC, spc_exp);
    wr(ECU_OFF_SAVED_ST, st_exp);
    fire('0, 1'b1, c, 1'b0, 1'b0, 1'b1, spc_exp);
    chk(o_status, st_exp);
    // Exception while blocked ends in a manual reset
    e.user_break = 1'b0;
    fire(e, 1'b0, c, 1'b0, 1'b0, 1'b1, RST_V);
    chk(o_manual_reset, 1'b1);
    rd(ECU_OFF_EXC_CODE, ECU_MRESET_CODE);
    // Ordinary request waits for the block bit to clear
    irq_go(1'b0, 1'b1, 1'b0);
    rd(ECU_OFF_PEND, 32'h1);
    wr(ECU_OFF_STATUS, 32'h0);
    irq_go(1'b0, 1'b0, 1'b1);
    rd(ECU_OFF_SAVED_PC, spc_exp);
    // Blocked nonmaskable request follows the control bit
    wr(ECU_OFF_CTRL, 32'h0);
    irq_go(1'b1, 1'b1, 1'b0);
    rd(ECU_OFF_PEND, 32'h2);
    wr(ECU_OFF_CTRL, 32'h1);
    irq_go(1'b1, 1'b0, 1'b1);
    irq_go(1'b1, 1'b1, 1'b1);
    // Sleep overrides the block bit
    @(posedge i_clk_sys);
    sleep <= 1'b1;
    irq_go(1'b0, 1'b1, 1'b1);
    @(posedge i_clk_sys);
    sleep <= 1'b0;
    // Second access fault checked only when a second transfer exists
    wr(ECU_OFF_STATUS, 32'h0);
    e.pc = $random(seed);
    e.valid = 1'b0;
    fire(e, 1'b0, c, 1'b0, 1'b1, 1'b0, EXC_V);
    fire(e, 1'b0, c, 1'b1, 1'b1, 1'b1, EXC_V);
    rd(ECU_OFF_SAVED_PC, e.pc);
    rd(ECU_OFF_EXC_CODE, CHK_C);
    // A fault on the first access alone is caught as well
    wr(ECU_OFF_STATUS, 32'h0);
    flta <= 1'b1;
    fire(e, 1'b0, c, 1'b1, 1'b0, 1'b1, EXC_V);
    results();
  end
endmodule // tb
